/* File: rtl/adc_cfg_pkg.sv */
// Constants shared by the serial configuration register bank.
// Assumes a 125 MHz system clock that also samples the serial pins.
package adc_cfg_pkg;
  // Register offsets (15-bit serial address space)
  localparam logic [14:0] OFF_SETUP = 15'h0000;
  localparam logic [14:0] OFF_MODE = 15'h0002;
  localparam logic [14:0] OFF_CLASS = 15'h0003;
  localparam logic [14:0] OFF_FAM_LO = 15'h0004;
  localparam logic [14:0] OFF_FAM_HI = 15'h0005;
  localparam logic [14:0] OFF_MAKER_LO = 15'h000c;
  localparam logic [14:0] OFF_MAKER_HI = 15'h000d;
  localparam logic [14:0] OFF_STREAM = 15'h0010;
  localparam logic [14:0] OFF_SYNC = 15'h0029;
  // Field positions
  localparam int SETUP_RST_BIT = 7;
  localparam int SETUP_ASC_BIT = 5;
  localparam int SETUP_IND_BIT = 4;
  localparam int STREAM_HOLD_BIT = 0;
  localparam logic [1:0] MODE_PWR_DOWN = 2'h3;
  // Reset values
  localparam logic [7:0] RST_SETUP = 8'h30;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [3:0] RST_CLASS_HI = 4'h0;
  localparam logic [7:0] RST_STREAM = 8'h00;
  localparam logic [7:0] RST_SYNC = 8'h00;
  // Frame layout
  localparam logic [3:0] CMD_LAST = 4'hf;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  // Soft reset hold time, rounded up to whole cycles
  localparam int SOFT_RST_NS = 750;
  localparam int CLK_PERIOD_NS = 8;
  localparam logic [7:0] SOFT_RST_CNT =
    8'((SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  typedef enum logic [1:0] {
    ST_CMD = 2'b00,
    ST_DATA = 2'b01,
    ST_SKIP = 2'b10
  } spi_state_t;
endpackage

/* File: rtl/spi_cfg_regs.sv */
// Serial configuration and identity register bank of the converter.
// Assumes SCLK, CS_N and SDI are synchronous to CLK and far slower.
// Frame: R/W bit (1 = read), 15-bit address, then streamed data bytes,
// MSB first; SDI sampled on SCLK rise, SDO changes on SCLK fall.

////////////////////////////////////////////////////////////////////////
// What this block does
// - Writing one to soft-reset bit resets all registers; bit reads zero.
// - Streaming address increments when ascend bit is one, else decrements.
// - Output-line indicator always reads one; read data only on SDO.
// - Mode field: zero normal, three power-down, one and two reserved.
// - Four-bit class code is fixed, read-only, ignores writes.
// - Sixteen-bit family code is fixed and read-only.
// - Sixteen-bit maker code is fixed and read-only.
// - Address-freeze bit keeps streaming address constant.
module spi_cfg_regs #(
  parameter logic [3:0] CLASS_CODE = 4'ha,    // Arbitrary value
  parameter logic [15:0] FAMILY_CODE = 16'h1234, // Arbitrary value
  parameter logic [15:0] MAKER_CODE = 16'h5a5a   // Arbitrary value
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SDI,
  output logic SDO,
  output logic [1:0] MODE,
  output logic POWER_DOWN,
  output logic [7:0] SYNC_CTRL,
  output logic CORE_RST_N
);

  adc_cfg_pkg::spi_state_t st_r;
  logic sclk_q_r;
  logic [3:0] bit_cnt_r;
  logic [15:0] rx_r;
  logic rd_r;
  logic [14:0] addr_r;
  logic [7:0] tx_r;
  logic sdo_r;
  logic [7:0] setup_r;
  logic [7:0] mode_r;
  logic [3:0] class_hi_r;
  logic [7:0] stream_r;
  logic [7:0] sync_r;
  logic pd_r;
  logic [7:0] soft_cnt_r;
  logic core_rst_n_r;

  logic rise;
  logic fall;
  logic busy;
  logic cmd_done;
  logic byte_done;
  logic [7:0] rx_byte;
  logic wr_en;
  logic soft_start;
  logic [14:0] addr_nxt;

  // Read view of one address; unmapped bytes read zero
  function automatic logic [7:0] rd_byte(input logic [14:0] a);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      adc_cfg_pkg::OFF_SETUP: begin
        d = setup_r;
        d[adc_cfg_pkg::SETUP_RST_BIT] = 1'b0;
        d[adc_cfg_pkg::SETUP_IND_BIT] = 1'b1;
      end
      adc_cfg_pkg::OFF_MODE: d = mode_r;
      adc_cfg_pkg::OFF_CLASS: d = {class_hi_r, CLASS_CODE};
      adc_cfg_pkg::OFF_FAM_LO: d = FAMILY_CODE[7:0];
      adc_cfg_pkg::OFF_FAM_HI: d = FAMILY_CODE[15:8];
      adc_cfg_pkg::OFF_MAKER_LO: d = MAKER_CODE[7:0];
      adc_cfg_pkg::OFF_MAKER_HI: d = MAKER_CODE[15:8];
      adc_cfg_pkg::OFF_STREAM: d = stream_r;
      adc_cfg_pkg::OFF_SYNC: d = sync_r;
      default: d = 8'h00;
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Serial edge detection and frame decode
  assign rise = SCLK & ~sclk_q_r;
  assign fall = ~SCLK & sclk_q_r;
  assign busy = soft_cnt_r != 8'h00;
  assign cmd_done = (st_r == adc_cfg_pkg::ST_CMD) && rise && !CS_N &&
    (bit_cnt_r == adc_cfg_pkg::CMD_LAST);
  assign byte_done = (st_r == adc_cfg_pkg::ST_DATA) && rise && !CS_N &&
    (bit_cnt_r == adc_cfg_pkg::BYTE_LAST);
  assign rx_byte = {rx_r[6:0], SDI};
  assign wr_en = byte_done && !rd_r && !busy;
  assign soft_start = wr_en && (addr_r == adc_cfg_pkg::OFF_SETUP) &&
    rx_byte[adc_cfg_pkg::SETUP_RST_BIT];

  // Next streaming address: hold beats ascend/descend
  always_comb begin
    if (stream_r[adc_cfg_pkg::STREAM_HOLD_BIT]) begin
      addr_nxt = addr_r;
    end else if (setup_r[adc_cfg_pkg::SETUP_ASC_BIT]) begin
      addr_nxt = addr_r + 15'h0001;
    end else begin
      addr_nxt = addr_r - 15'h0001;
    end
  end

  // Previous SCLK level
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sclk_q_r <= 1'b0;
    end else begin
      sclk_q_r <= SCLK;
    end
  end

  // Frame state; a frame cut by soft reset is dropped until CS_N rises
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= adc_cfg_pkg::ST_CMD;
      bit_cnt_r <= 4'h0;
    end else if (CS_N) begin
      st_r <= adc_cfg_pkg::ST_CMD;
      bit_cnt_r <= 4'h0;
    end else if (busy || soft_start) begin
      st_r <= adc_cfg_pkg::ST_SKIP;
      bit_cnt_r <= 4'h0;
    end else if (rise && st_r != adc_cfg_pkg::ST_SKIP) begin
      if (cmd_done || byte_done) begin
        st_r <= adc_cfg_pkg::ST_DATA;
        bit_cnt_r <= 4'h0;
      end else begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end
  end

  // Input shifter and command capture
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_r <= 16'h0000;
      rd_r <= 1'b0;
    end else begin
      if (rise && !CS_N) begin
        rx_r <= {rx_r[14:0], SDI};
      end
      if (cmd_done) begin
        rd_r <= rx_r[14];
      end
    end
  end

  // Working address: loaded by command, stepped after each data byte
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      addr_r <= 15'h0000;
    end else if (cmd_done) begin
      addr_r <= {rx_r[13:0], SDI};
    end else if (byte_done) begin
      addr_r <= addr_nxt;
    end
  end

  // Read shifter: byte loaded on the rise, bits leave on falls
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_r <= 8'h00;
      sdo_r <= 1'b0;
    end else if (CS_N) begin
      tx_r <= 8'h00;
      sdo_r <= 1'b0;
    end else if (cmd_done) begin
      tx_r <= rd_byte({rx_r[13:0], SDI});
    end else if (byte_done) begin
      tx_r <= rd_byte(addr_nxt);
    end else if (fall && st_r == adc_cfg_pkg::ST_DATA && rd_r) begin
      sdo_r <= tx_r[7];
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Soft reset timer; holds registers at defaults for the whole window
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      soft_cnt_r <= 8'h00;
      core_rst_n_r <= 1'b0;
    end else begin
      if (soft_start) begin
        soft_cnt_r <= adc_cfg_pkg::SOFT_RST_CNT;
      end else if (busy) begin
        soft_cnt_r <= soft_cnt_r - 8'h01;
      end
      core_rst_n_r <= !(soft_start || busy);
    end
  end

  // Writable registers; reserved bits kept as plain storage
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      setup_r <= adc_cfg_pkg::RST_SETUP;
      mode_r <= adc_cfg_pkg::RST_MODE;
      class_hi_r <= adc_cfg_pkg::RST_CLASS_HI;
      stream_r <= adc_cfg_pkg::RST_STREAM;
      sync_r <= adc_cfg_pkg::RST_SYNC;
    end else if (soft_start || busy) begin
      setup_r <= adc_cfg_pkg::RST_SETUP;
      mode_r <= adc_cfg_pkg::RST_MODE;
      class_hi_r <= adc_cfg_pkg::RST_CLASS_HI;
      stream_r <= adc_cfg_pkg::RST_STREAM;
      sync_r <= adc_cfg_pkg::RST_SYNC;
    end else if (wr_en) begin
      unique case (addr_r)
        adc_cfg_pkg::OFF_SETUP: setup_r <= rx_byte;
        adc_cfg_pkg::OFF_MODE: mode_r <= rx_byte;
        adc_cfg_pkg::OFF_CLASS: class_hi_r <= rx_byte[7:4];
        adc_cfg_pkg::OFF_STREAM: stream_r <= rx_byte;
        adc_cfg_pkg::OFF_SYNC: sync_r <= rx_byte;
        default: ;
      endcase
    end
  end

  // Registered power-down level; reserved codes run as normal operation
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pd_r <= 1'b0;
    end else begin
      pd_r <= mode_r[1:0] == adc_cfg_pkg::MODE_PWR_DOWN;
    end
  end

  assign SDO = sdo_r;
  assign MODE = mode_r[1:0];
  assign POWER_DOWN = pd_r;
  assign SYNC_CTRL = sync_r;
  assign CORE_RST_N = core_rst_n_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // Address of the command word completing this cycle; checks watch the
  // byte really loaded into the read shifter, not the decode function
  logic [14:0] cmd_addr;
  assign cmd_addr = {rx_r[13:0], SDI};

  property p_soft_start;
    soft_start |=> soft_cnt_r == adc_cfg_pkg::SOFT_RST_CNT && !CORE_RST_N
      ##1 setup_r == adc_cfg_pkg::RST_SETUP;
  endproperty
  a_soft_start: assert property (p_soft_start)
    else $error("soft reset did not start");

  property p_soft_end;
    soft_cnt_r == 8'h01 |=> !busy ##1 CORE_RST_N;
  endproperty
  a_soft_end: assert property (p_soft_end)
    else $error("soft reset window did not end");

  property p_inc;
    byte_done && !stream_r[0] && setup_r[5] |=>
      addr_r == $past(addr_r) + 15'h0001;
  endproperty
  a_inc: assert property (p_inc)
    else $error("address did not increment");

  property p_dec;
    byte_done && !stream_r[0] && !setup_r[5] |=>
      addr_r == $past(addr_r) - 15'h0001;
  endproperty
  a_dec: assert property (p_dec)
    else $error("address did not decrement");

  property p_ind;
    cmd_done && cmd_addr == adc_cfg_pkg::OFF_SETUP |=> tx_r[4] && !tx_r[7];
  endproperty
  a_ind: assert property (p_ind)
    else $error("setup read view wrong");

  property p_pd;
    ##1 POWER_DOWN == ($past(mode_r[1:0]) == 2'h3);
  endproperty
  a_pd: assert property (p_pd)
    else $error("power-down does not follow mode");

  property p_class;
    cmd_done && cmd_addr == adc_cfg_pkg::OFF_CLASS |=>
      tx_r[3:0] == CLASS_CODE;
  endproperty
  a_class: assert property (p_class)
    else $error("class code changed");

  property p_fam;
    (cmd_done && cmd_addr == adc_cfg_pkg::OFF_FAM_LO |=>
      tx_r == FAMILY_CODE[7:0]) and
    (cmd_done && cmd_addr == adc_cfg_pkg::OFF_FAM_HI |=>
      tx_r == FAMILY_CODE[15:8]);
  endproperty
  a_fam: assert property (p_fam)
    else $error("family code wrong");

  property p_maker;
    (cmd_done && cmd_addr == adc_cfg_pkg::OFF_MAKER_LO |=>
      tx_r == MAKER_CODE[7:0]) and
    (cmd_done && cmd_addr == adc_cfg_pkg::OFF_MAKER_HI |=>
      tx_r == MAKER_CODE[15:8]);
  endproperty
  a_maker: assert property (p_maker)
    else $error("maker code wrong");

  property p_hold;
    byte_done && stream_r[0] |=> $stable(addr_r);
  endproperty
  a_hold: assert property (p_hold)
    else $error("address moved under hold");

  property p_step_once;
    st_r == adc_cfg_pkg::ST_DATA && !byte_done |=> $stable(addr_r);
  endproperty
  a_step_once: assert property (p_step_once)
    else $error("address moved mid-byte");

  c_read: cover property (cmd_done && rx_r[14] ##[1:300] byte_done);
  c_soft: cover property (soft_start ##[90:100] CORE_RST_N);
  c_dec: cover property (byte_done && !setup_r[5]);
  c_hold: cover property (byte_done && stream_r[0]);

endmodule

/* File: tb/spi_host_model.sv */
// Host controller model for the serial configuration link.
// Assumes the bench clock; drives on its falling edge, SCLK idles low.
module spi_host_model (
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wr_data [8] = '{default: 8'h00};
  logic [7:0] rd_data [8];
  int bit_cycles = 2;

  ////////////////////////////////////////
  // Idle: deselected, clock still, data line at a known level
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b1;
  end

  // One bit: fall with new data, sample answer, rise to hand bit over
  task automatic bit_slot(input logic b, output logic got);
    sclk = 1'b0;
    sdi = b;
    repeat (bit_cycles) @(negedge clk);
    got = sdo;
    sclk = 1'b1;
    repeat (bit_cycles) @(negedge clk);
  endtask

  // Command word then n streamed bytes, MSB first
  task automatic frame(input logic rd, input logic [14:0] a, input int n);
    logic [15:0] cmd;
    logic got;
    cmd = {rd, a};
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      bit_slot(cmd[i], got);
    end
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_slot(wr_data[k][i], got);
        rd_data[k][i] = got;
      end
    end
    sclk = 1'b0;
    sdi = ~sdi; // Released line must not keep its last value
    repeat (bit_cycles) @(negedge clk);
    cs_n = 1'b1;
    repeat (bit_cycles) @(negedge clk);
  endtask
endmodule

/* File: tb/spi_cfg_regs_test.sv */
// Self-checking bench for the serial configuration register bank.
// Assumes the host model and the design files compiled before it.
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      $display("wrong value at %0t got %h exp %h", $time, got, exp); \
      bad_count++; \
    end \
  end

module spi_cfg_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] CLS = 4'hc; // Arbitrary value
  localparam logic [15:0] FAM = 16'h8e31; // Arbitrary value
  localparam logic [15:0] MKR = 16'h4bd7; // Arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, cs_n, sdi, sdo, power_down, core_rst_n;
  logic [1:0] mode;
  logic [7:0] sync_ctrl;
  int bad_count = 0;
  int compares = 0;

  ////////////////////////////////////////
  // 125 MHz clock
  always #4 clk = ~clk;

  spi_cfg_regs #(.CLASS_CODE(CLS), .FAMILY_CODE(FAM), .MAKER_CODE(MKR))
    spi_cfg_regs_inst (.CLK(clk), .RST_N(rst_n), .SCLK(sclk),
    .CS_N(cs_n), .SDI(sdi), .SDO(sdo), .MODE(mode),
    .POWER_DOWN(power_down), .SYNC_CTRL(sync_ctrl),
    .CORE_RST_N(core_rst_n));
  spi_host_model spi_host_model_inst (.clk(clk), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

  // Access helpers over the host model
  function automatic logic [7:0] rb(input int k);
    return spi_host_model_inst.rd_data[k];
  endfunction
  task automatic rd_n(input logic [14:0] a, input int n);
    spi_host_model_inst.frame(1'b1, a, n);
  endtask
  task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
    rd_n(a, 1);
    `CHK(rb(0), exp)
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    spi_host_model_inst.wr_data[0] = d;
    spi_host_model_inst.frame(1'b0, a, 1);
  endtask

  // Verdict and end of run
  task automatic conclude();
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog: a hung sequence still reaches the verdict
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    conclude();
  end

  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(negedge clk);
    `CHK(core_rst_n, 1'b0)
    `CHK(power_down, 1'b0)
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    rd_chk(15'h0000, 8'h30);
    rd_chk(15'h0010, 8'h00);
    `CHK(core_rst_n, 1'b1)
    // Ascending stream runs off the family code into a gap
    rd_n(15'h0003, 4);
    `CHK(rb(0), {4'h0, CLS})
    `CHK(rb(1), FAM[7:0])
    `CHK(rb(2), FAM[15:8])
    `CHK(rb(3), 8'h00)
    // Slow host reads the maker code
    spi_host_model_inst.bit_cycles = 3;
    rd_n(15'h000c, 2);
    `CHK(rb(0), MKR[7:0])
    `CHK(rb(1), MKR[15:8])
    spi_host_model_inst.bit_cycles = 2;
    wr(15'h0003, 8'hf5);
    rd_chk(15'h0003, {4'hf, CLS});
    // Every mode code, reserved ones act as normal
    for (int m = 0; m < 4; m++) begin
      wr(15'h0002, 8'(m));
      rd_chk(15'h0002, 8'(m));
      `CHK(mode, 2'(m))
      `CHK(power_down, 1'(m == 3))
    end
    // Descending stream; indicator bit ignores a zero write
    wr(15'h0000, 8'h00);
    rd_chk(15'h0000, 8'h10);
    rd_n(15'h0005, 3);
    `CHK(rb(0), FAM[15:8])
    `CHK(rb(1), FAM[7:0])
    `CHK(rb(2), {4'hf, CLS})
    // Frozen address: last streamed byte wins
    wr(15'h0010, 8'h01);
    for (int k = 0; k < 3; k++) begin
      spi_host_model_inst.wr_data[k] = 8'(8'h11 * (k + 1));
    end
    spi_host_model_inst.frame(1'b0, 15'h0029, 3);
    `CHK(sync_ctrl, 8'h33)
    rd_n(15'h0029, 2);
    `CHK(rb(0), 8'h33)
    `CHK(rb(1), 8'h33)
    // Soft reset restores every register
    wr(15'h0002, 8'h03);
    wr(15'h0000, 8'h80);
    `CHK(core_rst_n, 1'b0)
    repeat (100) @(negedge clk);
    `CHK(core_rst_n, 1'b1)
    `CHK(sync_ctrl, 8'h00)
    `CHK(power_down, 1'b0)
    `CHK(mode, 2'h0)
    rd_chk(15'h0000, 8'h30);
    rd_chk(15'h0010, 8'h00);
    rd_chk(15'h0003, {4'h0, CLS});
    conclude();
  end
endmodule
